// [cfg_link_pkg.sv]
// Shared constants and types for the serial configuration memory link
package cfg_link_pkg;
    localparam int unsigned INSTR_BITS = 8;
    localparam int unsigned ADDR_BITS = 24;
    localparam int unsigned BYTE_BITS = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [7:0] READ_OPCODE = 8'h03;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    // Top byte address per density
    localparam logic [23:0] TOP_128M = 24'hFFFFFF;
    localparam logic [23:0] TOP_64M = 24'h7FFFFF;
    localparam logic [23:0] TOP_16M = 24'h1FFFFF;
    localparam logic [23:0] TOP_4M = 24'h07FFFF;
    localparam logic [23:0] TOP_1M = 24'h01FFFF;
    // Sector and page field positions
    localparam int unsigned PAGE_LSB = 8;
    localparam int unsigned SECTOR_LSB_128M = 18;
    localparam int unsigned SECTOR_LSB_MID = 16;
    localparam int unsigned SECTOR_LSB_1M = 15;
    localparam logic [23:0] ADDR_RESET = 24'h000000;

    typedef enum logic [2:0] {
        DENS_128M,
        DENS_64M,
        DENS_16M,
        DENS_4M,
        DENS_1M
    } density_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INSTR,
        ST_ADDR,
        ST_DATA
    } link_state_t;

    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic sdi;
    } link_pins_t;

    typedef struct packed {
        logic [6:0] sector;
        logic [9:0] page;
    } location_t;
endpackage

// [config_memory_link.sv]
// Serial configuration memory slave with its data-feed FIFO
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clocking
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Fill side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // Drain side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic room, next_room;
    logic push, pop;

    always_comb begin
        push = in_valid_in && room;
        pop = out_ready_in && (count != '0);
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = (AW+1)'(count + {{AW{1'b0}}, push}
                     - {{AW{1'b0}}, pop});
        // Ready is its own flop, so no byte is taken against a stale ready
        next_room = (next_count != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            room <= 1'b0;
        end else if (ce_in) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            room <= next_room;
            if (push) begin
                mem[wr_ptr] <= in_data_in;
            end
        end
    end

    assign in_ready_out = room;
    assign out_data_out = mem[rd_ptr];
    assign out_valid_out = (count != '0);
endmodule // byte_fifo

module config_memory_link (
    // Clocking
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Serial link pins from the configuration master
    input wire logic config_serial_clock_in,
    input wire logic memory_select_n_in,
    input wire logic memory_serial_in_in,
    // Serial data back to the master
    output logic memory_data_out,
    output logic memory_data_oe_out,
    // Density strap
    input wire logic [2:0] density_in,
    // Array content feed
    input wire logic [7:0] fill_data_in,
    input wire logic fill_valid_in,
    output logic fill_ready_out,
    // Read status
    output logic read_active_out,
    output logic [23:0] read_addr_out,
    output logic [6:0] sector_out,
    output logic [9:0] page_out,
    output logic underrun_out
);
    // Pins are foreign to clk_in: two flops before use
    cfg_link_pkg::link_pins_t pins_meta, pins_sync, pins_prev;
    logic [2:0] dens_meta, dens_sync;
    cfg_link_pkg::link_state_t state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [4:0] addr_cnt, next_addr_cnt;
    logic [7:0] instr, next_instr, shreg, next_shreg;
    logic [23:0] addr, next_addr, top;
    logic [23:0] next_read_addr;
    logic next_data, next_oe, next_active, next_underrun;
    cfg_link_pkg::location_t loc, next_loc;
    logic rise, fall, selected, pop;
    logic [7:0] fifo_data;
    logic fifo_valid;

    byte_fifo #(
        .WIDTH(cfg_link_pkg::BYTE_BITS),
        .DEPTH(cfg_link_pkg::FIFO_DEPTH)
    ) feed (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .in_data_in(fill_data_in),
        .in_valid_in(fill_valid_in),
        .in_ready_out(fill_ready_out),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(pop)
    );

    always_comb begin
        rise = pins_sync.sclk && !pins_prev.sclk;
        fall = !pins_sync.sclk && pins_prev.sclk;
        selected = !pins_sync.sel_n;
        case (cfg_link_pkg::density_t'(dens_sync))
            cfg_link_pkg::DENS_128M: top = cfg_link_pkg::TOP_128M;
            cfg_link_pkg::DENS_64M: top = cfg_link_pkg::TOP_64M;
            cfg_link_pkg::DENS_16M: top = cfg_link_pkg::TOP_16M;
            cfg_link_pkg::DENS_4M: top = cfg_link_pkg::TOP_4M;
            default: top = cfg_link_pkg::TOP_1M;
        endcase
    end

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_addr_cnt = addr_cnt;
        next_instr = instr;
        next_shreg = shreg;
        next_addr = addr;
        next_read_addr = read_addr_out;
        next_data = memory_data_out;
        next_oe = memory_data_oe_out;
        next_active = read_active_out;
        next_underrun = underrun_out;
        next_loc = loc;
        pop = 1'b0;
        if (!selected) begin
            // Deselect aborts any access and frees the data line
            next_state = cfg_link_pkg::ST_IDLE;
            next_oe = 1'b0;
            next_active = 1'b0;
        end else begin
            case (state)
                cfg_link_pkg::ST_IDLE: begin
                    // Only a fresh select starts a frame, so a refused
                    // opcode leaves the link silent until reselect
                    if (pins_prev.sel_n) begin
                        next_state = cfg_link_pkg::ST_INSTR;
                        next_bit_cnt = 3'h0;
                        next_addr_cnt = 5'h00;
                        next_underrun = 1'b0;
                    end
                end
                cfg_link_pkg::ST_INSTR: begin
                    if (rise) begin
                        next_instr = {instr[6:0], pins_sync.sdi};
                        next_bit_cnt = 3'(bit_cnt + 1'b1);
                        if (bit_cnt == cfg_link_pkg::BIT_LAST) begin
                            next_state = ({instr[6:0], pins_sync.sdi}
                                == cfg_link_pkg::READ_OPCODE) ?
                                cfg_link_pkg::ST_ADDR :
                                cfg_link_pkg::ST_IDLE;
                        end
                    end
                end
                cfg_link_pkg::ST_ADDR: begin
                    if (rise) begin
                        next_addr = {addr[22:0], pins_sync.sdi};
                        next_addr_cnt = 5'(addr_cnt + 1'b1);
                        if (addr_cnt == cfg_link_pkg::ADDR_LAST) begin
                            next_addr = {addr[22:0], pins_sync.sdi} & top;
                            next_state = cfg_link_pkg::ST_DATA;
                            next_bit_cnt = 3'h0;
                            next_active = 1'b1;
                        end
                    end
                end
                cfg_link_pkg::ST_DATA: begin
                    if (fall) begin
                        next_oe = 1'b1;
                        next_bit_cnt = 3'(bit_cnt + 1'b1);
                        if (bit_cnt == 3'h0) begin
                            // Clock cannot be stalled: empty feed sends 0
                            pop = fifo_valid;
                            next_underrun = underrun_out || !fifo_valid;
                            next_data = fifo_valid && fifo_data[7];
                            next_shreg = fifo_valid ?
                                {fifo_data[6:0], 1'b0} : 8'h00;
                            next_read_addr = addr;
                            next_addr = 24'(addr + 1'b1) & top;
                            case (cfg_link_pkg::density_t'(dens_sync))
                                cfg_link_pkg::DENS_128M: next_loc =
                                    {1'b0,
                                     addr[23:cfg_link_pkg::SECTOR_LSB_128M],
                                     addr[17:cfg_link_pkg::PAGE_LSB]};
                                cfg_link_pkg::DENS_64M,
                                cfg_link_pkg::DENS_16M,
                                cfg_link_pkg::DENS_4M: next_loc =
                                    {addr[22:cfg_link_pkg::SECTOR_LSB_MID],
                                     2'h0, addr[15:cfg_link_pkg::PAGE_LSB]};
                                // Unused strap codes act as the smallest part
                                default: next_loc =
                                    {5'h00,
                                     addr[16:cfg_link_pkg::SECTOR_LSB_1M],
                                     3'h0, addr[14:cfg_link_pkg::PAGE_LSB]};
                            endcase
                        end else begin
                            next_data = shreg[7];
                            next_shreg = {shreg[6:0], 1'b0};
                        end
                    end
                end
                default: next_state = cfg_link_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pins_meta <= 3'h6;
            pins_sync <= 3'h6;
            pins_prev <= 3'h6;
            dens_meta <= 3'h0;
            dens_sync <= 3'h0;
            state <= cfg_link_pkg::ST_IDLE;
            bit_cnt <= 3'h0;
            addr_cnt <= 5'h00;
            instr <= 8'h00;
            shreg <= 8'h00;
            addr <= cfg_link_pkg::ADDR_RESET;
            read_addr_out <= cfg_link_pkg::ADDR_RESET;
            loc <= 17'h00000;
            memory_data_out <= 1'b0;
            memory_data_oe_out <= 1'b0;
            read_active_out <= 1'b0;
            underrun_out <= 1'b0;
        end else if (ce_in) begin
            pins_meta <= {config_serial_clock_in, memory_select_n_in,
                          memory_serial_in_in};
            pins_sync <= pins_meta;
            pins_prev <= pins_sync;
            dens_meta <= density_in;
            dens_sync <= dens_meta;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            addr_cnt <= next_addr_cnt;
            instr <= next_instr;
            shreg <= next_shreg;
            addr <= next_addr;
            read_addr_out <= next_read_addr;
            loc <= next_loc;
            memory_data_out <= next_data;
            memory_data_oe_out <= next_oe;
            read_active_out <= next_active;
            underrun_out <= next_underrun;
        end
    end

    assign sector_out = loc.sector;
    assign page_out = loc.page;
endmodule // config_memory_link
`default_nettype wire

// [link_checker.sv]
// Port assertions for the configuration memory link
`timescale 1ns/1ns
`default_nettype none
module link_checker (
    // Clock and link
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic config_serial_clock_in,
    input wire logic memory_select_n_in,
    input wire logic memory_data_out,
    input wire logic memory_data_oe_out,
    // Status
    input wire logic [2:0] density_in,
    input wire logic read_active_out,
    input wire logic [23:0] read_addr_out,
    input wire logic [6:0] sector_out,
    input wire logic [9:0] page_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    a_idle_quiet: assert property (
        memory_select_n_in [*6] |-> !memory_data_oe_out) else $error("oe on");
    // Sync latency puts the change two samples into the low half
    a_data_on_fall: assert property (
        memory_data_oe_out && $past(memory_data_oe_out) &&
        $changed(memory_data_out) |-> !$past(config_serial_clock_in) &&
        !$past(config_serial_clock_in, 2)) else $error("data edge");
    a_oe_after_addr: assert property (
        $rose(memory_data_oe_out) |-> read_active_out &&
        !$past(config_serial_clock_in)) else $error("oe early");
    a_addr_step: assert property (
        memory_data_oe_out && $past(memory_data_oe_out) &&
        $changed(read_addr_out) |-> read_addr_out == 24'h000000 ||
        read_addr_out == $past(read_addr_out) + 24'h000001)
        else $error("addr step");
    a_map_large: assert property (
        memory_data_oe_out && $stable(read_addr_out) && density_in == 3'h0
        |-> {sector_out, page_out} == {1'b0, read_addr_out[23:8]})
        else $error("map");
    a_map_small: assert property (
        memory_data_oe_out && $stable(read_addr_out) && density_in == 3'h4
        |-> {sector_out, page_out} ==
        {5'h00, read_addr_out[16:15], 3'h0, read_addr_out[14:8]})
        else $error("map small");
    a_map_mid: assert property (
        memory_data_oe_out && $stable(read_addr_out) &&
        (density_in inside {3'h1, 3'h2, 3'h3})
        |-> {sector_out, page_out} ==
        {read_addr_out[22:16], 2'h0, read_addr_out[15:8]})
        else $error("map mid");
endmodule // link_checker
`default_nettype wire

// [cfg_host_model.sv]
// Behavioural configuration master driving the serial link
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
    // Link outputs
    output var logic sclk_out,
    output var logic sel_n_out,
    output var logic sdi_out,
    // Link input and received bytes
    input wire logic data_in,
    output var logic [7:0] rx_out,
    output var logic rx_strobe_out
);
    logic [7:0] shift;
    initial begin
        sclk_out = 1'b1;
        sel_n_out = 1'b1;
        sdi_out = 1'b0;
        rx_out = 8'h00;
        rx_strobe_out = 1'b0;
        shift = 8'h00;
    end
    // Clock stands high between frames; 400 ns period within
    task automatic read_burst(input logic [7:0] op, input logic [23:0] a,
            input int n);
        logic [31:0] cmd;
        cmd = {op, a};
        #13 sel_n_out = 1'b0;
        #200;
        for (int i = 31; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdi_out = cmd[i];
            #200 sclk_out = 1'b1;
            #200;
        end
        for (int j = 0; j <= 8 * n; j++) begin
            sclk_out = 1'b0;
            rx_strobe_out = 1'b0;
            if (j > 0) shift = {shift[6:0], data_in};
            if (j > 0 && j % 8 == 0) begin
                rx_out = shift;
                rx_strobe_out = 1'b1;
            end
            #200 sclk_out = 1'b1;
            #200;
        end
        rx_strobe_out = 1'b0;
    endtask
    // Released input must not keep looking like the last bit
    task automatic deselect();
        sel_n_out = 1'b1;
        sdi_out = ~sdi_out;
    endtask
endmodule // cfg_host_model
`default_nettype wire

// [active_serial_config_flash_link_tb_top.sv]
// Testbench for the configuration memory link
`timescale 1ns/1ns
`default_nettype none
module active_serial_config_flash_link_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic config_serial_clock_in, memory_select_n_in, memory_serial_in_in;
    logic memory_data_out, memory_data_oe_out, fill_valid_in, fill_ready_out;
    logic read_active_out, underrun_out, link_data, rx_strobe;
    logic [7:0] fill_data_in, rx_byte;
    logic [2:0] density_in;
    logic [23:0] read_addr_out, a;
    logic [6:0] sector_out;
    logic [9:0] page_out;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    logic [23:0] a_tab[5] = '{24'hFC00FF, 24'hFF00FF, 24'h12FFFF, 24'h07FFFF,
        24'h0180FF};
    logic [23:0] top_tab[5] = '{cfg_link_pkg::TOP_128M, cfg_link_pkg::TOP_64M,
        cfg_link_pkg::TOP_16M, cfg_link_pkg::TOP_4M, cfg_link_pkg::TOP_1M};
    always #25 clk_in = ~clk_in;
    assign link_data = memory_data_oe_out ? memory_data_out : ~memory_data_out;
    cfg_host_model cfg_host_model_inst (.sclk_out(config_serial_clock_in),
        .sel_n_out(memory_select_n_in), .sdi_out(memory_serial_in_in),
        .data_in(link_data), .rx_out(rx_byte), .rx_strobe_out(rx_strobe));
    config_memory_link config_memory_link_inst (.clk_in, .rst_in,
        .ce_in(1'b1), .config_serial_clock_in, .memory_select_n_in,
        .memory_serial_in_in, .memory_data_out, .memory_data_oe_out,
        .density_in, .fill_data_in, .fill_valid_in, .fill_ready_out,
        .read_active_out, .read_addr_out, .sector_out, .page_out,
        .underrun_out);
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [16:0] exp_loc(input logic [23:0] x);
        case (density_in)
            3'h0: return {1'b0, x[23:8]};
            3'h4: return {5'h00, x[16:15], 3'h0, x[14:8]};
            default: return {x[22:16], 2'h0, x[15:8]};
        endcase
    endfunction
    task automatic fill(input int n);
        logic [7:0] b;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            b = 8'($urandom);
            exp_q.push_back(b);
            fill_data_in <= b;
            fill_valid_in <= 1'b1;
        end
        @(posedge clk_in);
        fill_valid_in <= 1'b0;
    endtask
    // One extra fall pops an empty buffer, so underrun is expected
    task automatic after_read(input logic [23:0] x);
        @(posedge clk_in);
        check(read_addr_out, x);
        check(24'({sector_out, page_out}), 24'(exp_loc(x)));
        check(24'({read_active_out, underrun_out}), 24'h3);
        cfg_host_model_inst.deselect();
        repeat (6) @(posedge clk_in);
        check(24'(memory_data_oe_out), 24'h0);
    endtask
    // Let the byte settle past the strobe's own time step
    always @(posedge rx_strobe) begin
        #1;
        check(24'(rx_byte), 24'(exp_q.pop_front()));
    end
    initial begin
        #2000000;
        n_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'h46B3));
        fill_valid_in = 1'b0;
        fill_data_in = 8'h00;
        density_in = 3'h0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check(24'({memory_data_oe_out, read_active_out}), 24'h0);
        check(24'(underrun_out), 24'h0);
        for (int i = 0; i < 5; i++) begin
            density_in <= 3'(i);
            fill(1);
            cfg_host_model_inst.read_burst(cfg_link_pkg::READ_OPCODE, a_tab[i], 1);
            after_read((a_tab[i] + 24'h1) & top_tab[i]);
        end
        density_in <= 3'h0;
        a = 24'($urandom) & 24'hFFFF00;
        fill(8);
        repeat (2) @(posedge clk_in);
        check(24'(fill_ready_out), 24'h0);
        cfg_host_model_inst.read_burst(cfg_link_pkg::READ_OPCODE, a, 8);
        after_read(a + 24'h8);
        cfg_host_model_inst.read_burst(8'h0B, a, 0);
        @(posedge clk_in);
        check(24'({memory_data_oe_out, read_active_out}), 24'h0);
        cfg_host_model_inst.deselect();
        repeat (4) @(posedge clk_in);
        check(24'(exp_q.size()), 24'h0);
        test_done();
    end
endmodule // active_serial_config_flash_link_tb_top
bind config_memory_link link_checker link_checker_inst (.clk_in, .rst_in,
    .config_serial_clock_in, .memory_select_n_in, .memory_data_out,
    .memory_data_oe_out, .density_in, .read_active_out, .read_addr_out,
    .sector_out, .page_out);
`default_nettype wire
